/* File: rtl/rso_top.sv */
// radio status, identification, tuning and debug output registers
// assumes a one-cycle strobe register port and inputs synchronous to i_core_clk
//
// The implementer's own choice: the plain strobed port.
`default_nettype none

module rso_top
  import rso_pkg::*;
#(
  // arbitrary revision value
  parameter rso_byte_t CHIP_REV = 8'h11,
  // arbitrary identification value
  parameter rso_byte_t CHIP_ID = 8'h5a
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rdata,
  // radio status inputs
  input wire logic i_tx_active,
  input wire logic [7:0] i_rx_count,
  input wire logic i_sfd,
  input wire logic i_cca,
  input wire logic i_filter_en,
  input wire logic i_frame_passed,
  input wire logic i_frame_complete,
  // frame events
  input wire logic i_frame_end,
  input wire logic i_frame_is_ack,
  output logic o_radio_irq_set,
  // configuration outputs
  output logic [3:0] o_xtal_tune,
  output logic [1:0] o_hssd_src,
  // debug pins, port 1 pins 4 to 7
  output logic [3:0] o_p1_dbg,
  output logic [3:0] o_p1_dbg_oe_n
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [6:0] thr_q;
  logic [6:0] io_b_q;
  logic [6:0] io_c_q;
  logic [5:0] io_d_q;
  logic [3:0] tune_q;
  logic ack_en_q;
  logic [7:0] rdata_q;
  logic irq_set_q;

  // sampled status bits
  logic tx_q;
  logic rxdata_q;
  logic thr_flag_q;
  logic sfd_q;
  logic cca_q;

  // decoded strobes
  logic wr_io_a;
  logic wr_io_b;
  logic wr_io_c;
  logic wr_io_d;
  logic wr_tune;
  logic wr_interrupt_source_select;
  logic thr_cond;
  rso_byte_t rd_mux;

  rso_dbg_if #(.N(NUM_DBG)) dbg ();

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign wr_io_a = i_wr_en && (i_addr == ADDR_IO_A);
  assign wr_io_b = i_wr_en && (i_addr == ADDR_IO_B);
  assign wr_io_c = i_wr_en && (i_addr == ADDR_IO_C);
  assign wr_io_d = i_wr_en && (i_addr == ADDR_IO_D);
  assign wr_tune = i_wr_en && (i_addr == ADDR_TUNE);
  assign wr_interrupt_source_select = i_wr_en && (i_addr == ADDR_INTERRUPT_SOURCE_SELECT);

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  // threshold level
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thr_q <= THR_RST;
    end else if (wr_io_a) begin
      thr_q <= i_wdata[6:0];
    end
  end

  // clear channel and delimiter pin configuration
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      io_b_q <= IO_BC_RST;
      io_c_q <= IO_BC_RST;
    end else begin
      if (wr_io_b) begin
        io_b_q <= i_wdata[6:0];
      end
      if (wr_io_c) begin
        io_c_q <= i_wdata[6:0];
      end
    end
  end

  // threshold and queue pin configuration
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      io_d_q <= IO_D_RST;
    end else if (wr_io_d) begin
      io_d_q <= i_wdata[5:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tune_q <= TUNE_RST;
    end else if (wr_tune) begin
      tune_q <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_en_q <= ACK_EN_RST;
    end else if (wr_interrupt_source_select) begin
      ack_en_q <= i_wdata[0];
    end
  end

  // ------------------------------------------------------------
  // status sampling
  // ------------------------------------------------------------
  // threshold condition
  assign thr_cond = i_frame_complete
                    || ((i_rx_count > {1'b0, thr_q}) && (!i_filter_en || i_frame_passed));

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_q <= 1'b0;
      rxdata_q <= 1'b0;
      thr_flag_q <= 1'b0;
      sfd_q <= 1'b0;
      cca_q <= 1'b0;
    end else begin
      tx_q <= i_tx_active;
      rxdata_q <= (i_rx_count != 8'h00);
      thr_flag_q <= thr_cond;
      sfd_q <= i_sfd;
      cca_q <= i_cca;
    end
  end

  // ------------------------------------------------------------
  // frame event gating
  // ------------------------------------------------------------
  // ack frames set the flag only when enabled
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_set_q <= 1'b0;
    end else begin
      irq_set_q <= i_frame_end && (!i_frame_is_ack || ack_en_q);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      ADDR_IO_A: begin
        rd_mux = {1'b0, thr_q};
      end
      ADDR_IO_B: begin
        rd_mux = {1'b0, io_b_q};
      end
      ADDR_IO_C: begin
        rd_mux = {1'b0, io_c_q};
      end
      ADDR_IO_D: begin
        rd_mux = {2'h0, io_d_q};
      end
      ADDR_REV: begin
        rd_mux = CHIP_REV;
      end
      ADDR_ID: begin
        rd_mux = CHIP_ID;
      end
      ADDR_STATUS: begin
        rd_mux = {3'h0, tx_q, rxdata_q, thr_flag_q, sfd_q, cca_q};
      end
      ADDR_TUNE: begin
        rd_mux = {4'h0, tune_q};
      end
      ADDR_INTERRUPT_SOURCE_SELECT: begin
        rd_mux = {7'h00, ack_en_q};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // read data stands one cycle only
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd_en ? rd_mux : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // debug routing
  // ------------------------------------------------------------
  // channel signals
  assign dbg.sig[CH_RXDATA] = rxdata_q;
  assign dbg.sig[CH_THR] = thr_flag_q;
  assign dbg.sig[CH_SFD] = sfd_q;
  assign dbg.sig[CH_CCA] = cca_q;

  assign dbg.pol[CH_RXDATA] = io_d_q[IOD_RX_POL];
  assign dbg.pol[CH_THR] = io_d_q[IOD_THR_POL];
  assign dbg.pol[CH_SFD] = io_c_q[IOBC_POL];
  assign dbg.pol[CH_CCA] = io_b_q[IOBC_POL];

  assign dbg.en[CH_RXDATA] = io_d_q[IOD_RX_OE];
  assign dbg.en[CH_THR] = io_d_q[IOD_THR_OE];
  // delimiter and clear channel pin enables, selector must be zero
  assign dbg.en[CH_SFD] = io_c_q[IOBC_OE] && (io_c_q[4:0] == 5'h00);
  assign dbg.en[CH_CCA] = io_b_q[IOBC_OE] && (io_b_q[4:0] == 5'h00);

  rso_dbg_out #(
    .N(NUM_DBG)
  ) u_dbg_out (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .dbg(dbg)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_rdata = rdata_q;
  assign o_radio_irq_set = irq_set_q;
  assign o_xtal_tune = tune_q;
  assign o_hssd_src = io_d_q[5:4];
  assign o_p1_dbg = dbg.pin;
  assign o_p1_dbg_oe_n = dbg.oe_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_rev_read;
    i_rd_en && (i_addr == ADDR_REV) |=> o_rdata == CHIP_REV;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision read wrong");

  property p_id_read;
    i_rd_en && (i_addr == ADDR_ID) |=> o_rdata == CHIP_ID;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification read wrong");

  property p_tx_bit;
    i_rd_en && (i_addr == ADDR_STATUS) |=> o_rdata[ST_TX] == $past(i_tx_active, 2);
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmit bit wrong");

  property p_rxdata_bit;
    i_rd_en && (i_addr == ADDR_STATUS)
      |=> o_rdata[ST_RXDATA] == ($past(i_rx_count, 2) != 8'h00);
  endproperty
  a_rxdata_bit: assert property (p_rxdata_bit)
    else $error("queue data bit wrong");

  property p_thr_above;
    i_rstn && !i_filter_en && (i_rx_count > {1'b0, thr_q}) |=> thr_flag_q;
  endproperty
  a_thr_above: assert property (p_thr_above)
    else $error("threshold flag missing");

  property p_thr_below;
    !i_frame_complete && (i_rx_count <= {1'b0, thr_q}) |=> !thr_flag_q;
  endproperty
  a_thr_below: assert property (p_thr_below)
    else $error("threshold flag set too early");

  property p_thr_filter;
    i_filter_en && !i_frame_passed && !i_frame_complete |=> !thr_flag_q;
  endproperty
  a_thr_filter: assert property (p_thr_filter)
    else $error("threshold flag before filtering");

  property p_thr_complete;
    i_rstn && i_frame_complete |=> thr_flag_q;
  endproperty
  a_thr_complete: assert property (p_thr_complete)
    else $error("threshold flag missing on complete frame");

  property p_status_top;
    i_rd_en && (i_addr == ADDR_STATUS)
      |=> o_rdata[7:5] == 3'h0 && o_rdata[ST_SFD] == $past(i_sfd, 2);
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("status upper bits or delimiter wrong");

  property p_tune_rw;
    wr_tune ##1 !wr_tune ##1 i_rd_en && (i_addr == ADDR_TUNE)
      |=> o_rdata == {4'h0, $past(i_wdata[3:0], 3)};
  endproperty
  a_tune_rw: assert property (p_tune_rw)
    else $error("tuning field read back wrong");

  property p_ack_gate;
    i_rstn && i_frame_end && i_frame_is_ack |=> o_radio_irq_set == $past(ack_en_q);
  endproperty
  a_ack_gate: assert property (p_ack_gate)
    else $error("ack frame gating wrong");

  property p_sfd_oe;
    !io_c_q[IOBC_OE] |=> o_p1_dbg_oe_n[CH_SFD];
  endproperty
  a_sfd_oe: assert property (p_sfd_oe)
    else $error("delimiter pin driven while disabled");

  property p_thr_oe;
    io_d_q[IOD_THR_OE] |=> !o_p1_dbg_oe_n[CH_THR];
  endproperty
  a_thr_oe: assert property (p_thr_oe)
    else $error("threshold pin not driven");

  property p_thr_pin;
    i_rstn && !i_frame_complete && !i_filter_en ##1 1'b1
      |=> o_p1_dbg[CH_THR] == (($past(i_rx_count, 2) > {1'b0, $past(thr_q, 2)})
                               ^ $past(io_d_q[IOD_THR_POL]));
  endproperty
  a_thr_pin: assert property (p_thr_pin)
    else $error("threshold pin level wrong");

  property p_cca_pin;
    i_rstn |-> ##2 o_p1_dbg[CH_CCA] == ($past(i_cca, 2) ^ $past(io_b_q[IOBC_POL]));
  endproperty
  a_cca_pin: assert property (p_cca_pin)
    else $error("clear channel pin level wrong");

endmodule : rso_top

`default_nettype wire

/* File: pkg/rso_pkg.sv */
// constants for the radio status and debug output register bank
// assumes an 8-bit register port with a 16-bit address

`default_nettype none

package rso_pkg;

  typedef logic [7:0] rso_byte_t;
  typedef logic [15:0] rso_addr_t;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam rso_addr_t ADDR_IO_A = 16'hdf4f;
  localparam rso_addr_t ADDR_IO_B = 16'hdf50;
  localparam rso_addr_t ADDR_IO_C = 16'hdf51;
  localparam rso_addr_t ADDR_IO_D = 16'hdf52;
  localparam rso_addr_t ADDR_REV = 16'hdf60;
  localparam rso_addr_t ADDR_ID = 16'hdf61;
  localparam rso_addr_t ADDR_STATUS = 16'hdf62;
  localparam rso_addr_t ADDR_TUNE = 16'hdf63;
  localparam rso_addr_t ADDR_INTERRUPT_SOURCE_SELECT = 16'hdf64;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [6:0] THR_RST = 7'h40;
  localparam logic [3:0] TUNE_RST = 4'hf;
  localparam logic ACK_EN_RST = 1'b0;
  localparam logic [6:0] IO_BC_RST = 7'h00;
  localparam logic [5:0] IO_D_RST = 6'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_TX = 4;
  localparam int ST_RXDATA = 3;
  localparam int ST_THR = 2;
  localparam int ST_SFD = 1;
  localparam int ST_CCA = 0;
  localparam int IOBC_OE = 6;
  localparam int IOBC_POL = 5;
  localparam int IOD_THR_OE = 3;
  localparam int IOD_THR_POL = 2;
  localparam int IOD_RX_OE = 1;
  localparam int IOD_RX_POL = 0;

  // ------------------------------------------------------------
  // debug channels, port 1 pins 4 to 7
  // ------------------------------------------------------------
  localparam int NUM_DBG = 4;
  localparam int CH_RXDATA = 0;
  localparam int CH_THR = 1;
  localparam int CH_SFD = 2;
  localparam int CH_CCA = 3;

endpackage : rso_pkg

`default_nettype wire

/* File: pkg/rso_dbg_if.sv */
// signals between the register bank and the debug pin driver
// assumes both ends share one clock
`default_nettype none

interface rso_dbg_if #(
  parameter int N = 4
);
  logic [N-1:0] sig;
  logic [N-1:0] pol;
  logic [N-1:0] en;
  logic [N-1:0] pin;
  logic [N-1:0] oe_n;

  modport src (output sig, output pol, output en, input pin, input oe_n);
  modport drv (input sig, input pol, input en, output pin, output oe_n);
endinterface : rso_dbg_if

`default_nettype wire

/* File: rtl/rso_dbg_out.sv */
// debug pin driver: polarity and enable per channel
// assumes sig, pol and en come from the same clock domain
`default_nettype none

module rso_dbg_out #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // channels
  rso_dbg_if.drv dbg
);

  // ------------------------------------------------------------
  // per channel output flops
  // ------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_ch
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        dbg.pin[g] <= 1'b0;
      end else begin
        dbg.pin[g] <= dbg.sig[g] ^ dbg.pol[g];
      end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        dbg.oe_n[g] <= 1'b1;
      end else begin
        dbg.oe_n[g] <= ~dbg.en[g];
      end
    end
  end

endmodule : rso_dbg_out

`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the radio status and debug output register bank
// assumes the one-cycle strobe register port and fixed latencies of rso_top
`default_nettype none

module tb;
  import rso_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // arbitrary identity values
  localparam rso_byte_t REV_VAL = 8'h2c;
  localparam rso_byte_t ID_VAL = 8'h7e;

  typedef struct packed {
    logic tx;
    logic [7:0] cnt;
    logic sfd;
    logic cca;
    logic filt;
    logic pass;
    logic cmpl;
    logic [7:0] exp;
  } rso_row_t;

  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] o_rdata;
  logic i_tx_active = 1'b0;
  logic [7:0] i_rx_count = 8'h00;
  logic i_sfd = 1'b0;
  logic i_cca = 1'b0;
  logic i_filter_en = 1'b0;
  logic i_frame_passed = 1'b0;
  logic i_frame_complete = 1'b0;
  logic i_frame_end = 1'b0;
  logic i_frame_is_ack = 1'b0;
  logic o_radio_irq_set;
  logic [3:0] o_xtal_tune;
  logic [1:0] o_hssd_src;
  logic [3:0] o_p1_dbg;
  logic [3:0] o_p1_dbg_oe_n;
  int fails = 0;
  int n_tests = 0;
  rso_row_t rows [11];

  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end

  rso_top #(.CHIP_REV(REV_VAL), .CHIP_ID(ID_VAL)) dut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata), .i_tx_active(i_tx_active),
    .i_rx_count(i_rx_count), .i_sfd(i_sfd), .i_cca(i_cca), .i_filter_en(i_filter_en),
    .i_frame_passed(i_frame_passed), .i_frame_complete(i_frame_complete),
    .i_frame_end(i_frame_end), .i_frame_is_ack(i_frame_is_ack),
    .o_radio_irq_set(o_radio_irq_set), .o_xtal_tune(o_xtal_tune), .o_hssd_src(o_hssd_src),
    .o_p1_dbg(o_p1_dbg), .o_p1_dbg_oe_n(o_p1_dbg_oe_n)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : tick

  task automatic wr(input rso_addr_t a, input rso_byte_t d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic chk_rd(input string name, input rso_addr_t a, input rso_byte_t exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    @(negedge i_core_clk);
    chk_byte(name, exp, o_rdata);
  endtask : chk_rd

  task automatic set_in(input rso_row_t r);
    @(posedge i_core_clk);
    i_tx_active <= r.tx;
    i_rx_count <= r.cnt;
    i_sfd <= r.sfd;
    i_cca <= r.cca;
    i_filter_en <= r.filt;
    i_frame_passed <= r.pass;
    i_frame_complete <= r.cmpl;
  endtask : set_in

  task automatic event_chk(input logic ack, input logic exp);
    @(posedge i_core_clk);
    i_frame_end <= 1'b1;
    i_frame_is_ack <= ack;
    @(posedge i_core_clk);
    i_frame_end <= 1'b0;
    @(negedge i_core_clk);
    chk_byte("irq_set", {7'h00, exp}, {7'h00, o_radio_irq_set});
    @(negedge i_core_clk);
    chk_byte("irq_set_after", 8'h00, {7'h00, o_radio_irq_set});
  endtask : event_chk

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge i_core_clk);
    fails++;
    $display("mismatch watchdog expected %h seen %h", 8'h00, 8'h01);
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{0, 8'h00, 0, 0, 0, 0, 0, 8'h00}, '{1, 8'h00, 0, 0, 0, 0, 0, 8'h10},
             '{0, 8'h01, 0, 0, 0, 0, 0, 8'h08}, '{0, 8'h40, 0, 0, 0, 0, 0, 8'h08},
             '{0, 8'h41, 0, 0, 0, 0, 0, 8'h0c}, '{0, 8'h41, 0, 0, 1, 0, 0, 8'h08},
             '{0, 8'h41, 0, 0, 1, 1, 0, 8'h0c}, '{0, 8'h05, 0, 0, 1, 0, 1, 8'h0c},
             '{0, 8'h00, 1, 0, 0, 0, 0, 8'h02}, '{0, 8'h00, 0, 1, 0, 0, 0, 8'h01},
             '{1, 8'hff, 1, 1, 0, 0, 0, 8'h1f}};
    tick(20);
    i_rstn <= 1'b1;
    // status rows
    foreach (rows[i]) begin
      set_in(rows[i]);
      tick(2);
      chk_rd("status", ADDR_STATUS, rows[i].exp);
    end
    $display("test status_rows done");
    // read-only places and unmapped address
    set_in('0);
    wr(ADDR_REV, 8'hff);
    wr(ADDR_ID, 8'hff);
    wr(ADDR_STATUS, 8'hff);
    wr(16'hdf65, 8'hff);
    chk_rd("revision", ADDR_REV, REV_VAL);
    chk_rd("ident", ADDR_ID, ID_VAL);
    chk_rd("status_ro", ADDR_STATUS, 8'h00);
    chk_rd("unmapped", 16'hdf65, 8'h00);
    $display("test read_only done");
    // tuning field, boundaries
    wr(ADDR_TUNE, 8'ha5);
    chk_rd("tune", ADDR_TUNE, 8'h05);
    chk_byte("tune_out", 8'h05, {4'h0, o_xtal_tune});
    wr(ADDR_TUNE, 8'hf0);
    chk_rd("tune_zero", ADDR_TUNE, 8'h00);
    $display("test tuning done");
    // threshold level boundary
    wr(ADDR_IO_A, 8'hff);
    chk_rd("thr_level", ADDR_IO_A, 8'h7f);
    wr(ADDR_IO_A, 8'h05);
    set_in('{0, 8'h05, 0, 0, 0, 0, 0, 8'h00});
    tick(2);
    chk_rd("thr_eq", ADDR_STATUS, 8'h08);
    set_in('{0, 8'h06, 0, 0, 0, 0, 0, 8'h00});
    tick(2);
    chk_rd("thr_gt", ADDR_STATUS, 8'h0c);
    $display("test threshold done");
    // ack frame enable
    event_chk(1'b1, 1'b0);
    event_chk(1'b0, 1'b1);
    wr(ADDR_INTERRUPT_SOURCE_SELECT, 8'hff);
    chk_rd("interrupt_source_select", ADDR_INTERRUPT_SOURCE_SELECT, 8'h01);
    event_chk(1'b1, 1'b1);
    $display("test ack_enable done");
    // debug pins: queue pol on, threshold on, delimiter on, clear channel inverted
    set_in('{0, 8'h41, 1, 0, 0, 0, 0, 8'h00});
    wr(ADDR_IO_A, 8'h40);
    wr(ADDR_IO_D, 8'h3b);
    wr(ADDR_IO_C, 8'h40);
    wr(ADDR_IO_B, 8'h60);
    tick(3);
    @(negedge i_core_clk);
    chk_byte("pins", 8'h0e, {4'h0, o_p1_dbg});
    chk_byte("pins_oe_n", 8'h00, {4'h0, o_p1_dbg_oe_n});
    chk_byte("hssd", 8'h03, {6'h00, o_hssd_src});
    wr(ADDR_IO_C, 8'h00);
    wr(ADDR_IO_D, 8'h02);
    tick(3);
    @(negedge i_core_clk);
    chk_byte("pins_off_oe_n", 8'h06, {4'h0, o_p1_dbg_oe_n});
    // clear channel pin only with a zero selector
    wr(ADDR_IO_B, 8'h61);
    chk_rd("io_b_sel", ADDR_IO_B, 8'h61);
    tick(2);
    @(negedge i_core_clk);
    chk_byte("cca_sel_oe_n", 8'h0e, {4'h0, o_p1_dbg_oe_n});
    $display("test debug_pins done");
    // reset in mid-run
    wr(ADDR_TUNE, 8'h03);
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    tick(2);
    @(negedge i_core_clk);
    chk_byte("rst_rdata", 8'h00, o_rdata);
    chk_byte("rst_oe_n", 8'h0f, {4'h0, o_p1_dbg_oe_n});
    chk_byte("rst_tune", 8'h0f, {4'h0, o_xtal_tune});
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    chk_rd("rst_io_a", ADDR_IO_A, 8'h40);
    chk_rd("rst_io_b", ADDR_IO_B, 8'h00);
    chk_rd("rst_io_c", ADDR_IO_C, 8'h00);
    chk_rd("rst_io_d", ADDR_IO_D, 8'h00);
    chk_rd("rst_tune_rd", ADDR_TUNE, 8'h0f);
    chk_rd("rst_interrupt_source_select", ADDR_INTERRUPT_SOURCE_SELECT, 8'h00);
    chk_rd("rst_status", ADDR_STATUS, 8'h0e);
    $display("test reset done");
    summarize();
  end
endmodule : tb

`default_nettype wire
